// *** src/wake_cfg_pkg.sv ***
// Package: register layout and types for the wake filter configuration
package wake_cfg_pkg;

    // Register addresses on the serial command interface (5-bit)
    localparam logic [4:0] ADDR_WAKE_ID_MASK_HIGH  = 5'h0f;
    localparam logic [4:0] ADDR_WAKE_FILTER_CONFIG = 5'h10;

    // Reset values
    localparam logic [15:0] RST_WAKE_ID_MASK_HIGH  = 16'h0000;
    localparam logic [15:0] RST_WAKE_FILTER_CONFIG = 16'h0000;

    // Mask register field positions
    localparam int STD_MASK_MSB = 12;
    localparam int STD_MASK_LSB = 2;
    localparam int EXT_MASK_MSB = 1;
    localparam int EXT_MASK_LSB = 0;
    localparam logic [15:0] MASK_REG_WRITABLE = 16'h1fff;

    // Config register field positions
    localparam int SAMPLE_MSB   = 6;
    localparam int SAMPLE_LSB   = 4;
    localparam int BITRATE_MSB  = 2;
    localparam int BITRATE_LSB  = 1;
    localparam int SELECTIVE_WAKE_ENABLE_BIT    = 0;
    localparam logic [15:0] CFG_REG_WRITABLE = 16'hff77;

    // Bit-rate codes
    localparam logic [1:0] BITRATE_500K = 2'h0;
    localparam logic [1:0] BITRATE_125K = 2'h3;

    // Recommended sample point code (81.5 percent)
    localparam logic [2:0] SAMPLE_OPTIMUM = 3'h5;

    // One register write or read request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  addr;
        logic [15:0] data;
    } reg_req_s;

    // Settings handed to the frame matcher
    typedef struct packed {
        logic [10:0] std_ident_mask;
        logic [1:0]  ext_ident_mask;
        logic [2:0]  sample_sel;
        logic [1:0]  bitrate_select;
        logic        selective_wake_enable;
    } filter_cfg_s;

endpackage

// *** src/ident_compare.sv ***
// Masked identifier comparison for wake frame matching
`timescale 1ns/100ps
module ident_compare #(
    parameter int WIDTH = 11
) (
    input  wire logic [WIDTH-1:0] rx_ident_in,
    input  wire logic [WIDTH-1:0] ref_ident_in,
    input  wire logic [WIDTH-1:0] mask_in,
    output logic                  match_out
);
    // A mask bit of 1 drops that bit from the compare
    assign match_out = &((~(rx_ident_in ^ ref_ident_in)) | mask_in);
endmodule

// *** src/wake_filter_cfg.sv ***
// Wake filter configuration registers and masked identifier match
//
// Functional notes
// - Standard ident mask in mask reg bits 12:2
// - Mask bit 1 ignores ident bit
// - Ext ident 17:16 masks in bits 1:0
// - Ext mask bit 1 ignores ext bit
// - Ext compare only when extension select set
// - Sample point selector bits 6:4, 71.5 up
// - Config bits 15:1 locked while enabled
// - Clearing the enable always accepted
`timescale 1ns/100ps
module wake_filter_cfg
    import wake_cfg_pkg::*;
(
    input  wire logic                      clock_in,
    input  wire logic                      rst_in,
    input  wire wake_cfg_pkg::reg_req_s    req_in,
    input  wire logic                      ident_extension_select_in,
    input  wire logic [10:0]               rx_std_ident_in,
    input  wire logic [1:0]                rx_ext_ident_top_in,
    input  wire logic [10:0]               ref_std_ident_in,
    input  wire logic [1:0]                ref_ext_ident_top_in,
    output wake_cfg_pkg::filter_cfg_s      cfg_out,
    output logic [15:0]                    rd_data_out,
    output logic                           rd_valid_out,
    output logic                           ident_match_out
);
    import wake_cfg_pkg::*;

    // Register state and next values
    logic [15:0] mask_reg_q;
    logic [15:0] mask_reg_d;
    logic [15:0] cfg_reg_q;
    logic [15:0] cfg_reg_d;
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic        rd_valid_q;
    logic        rd_valid_d;
    logic        match_q;
    logic        match_d;
    filter_cfg_s cfg_q;
    filter_cfg_s cfg_d;

    // Decode and write-data helpers
    logic        sel_mask;
    logic        sel_cfg;
    logic        wr_mask;
    logic        wr_cfg;
    logic        locked;
    logic        enable_d;
    logic [15:0] mask_wr_data;
    logic [15:0] cfg_wr_data;
    logic [15:0] cfg_upper_d;

    // Identifier compare results
    logic        std_hit;
    logic        ext_hit;
    logic        ext_needed;

    // True when this request addresses the given register
    function automatic logic reg_hit(
        input reg_req_s   req,
        input logic [4:0] addr
    );
        return req.valid && (req.addr == addr);
    endfunction

    // Reserved bits hold no state, so they are dropped before storing
    function automatic logic [15:0] keep_writable(
        input logic [15:0] data,
        input logic [15:0] writable
    );
        return data & writable;
    endfunction

    // Address decode
    assign sel_mask = reg_hit(req_in, ADDR_WAKE_ID_MASK_HIGH);
    assign sel_cfg  = reg_hit(req_in, ADDR_WAKE_FILTER_CONFIG);
    assign wr_mask  = sel_mask && req_in.write;
    assign wr_cfg   = sel_cfg && req_in.write;

    // The enable bit doubles as the lock for the upper config bits
    assign locked = cfg_reg_q[SELECTIVE_WAKE_ENABLE_BIT];

    // Mask register: bits 15:13 read back zero whatever is written
    assign mask_wr_data = keep_writable(req_in.data, MASK_REG_WRITABLE);
    assign mask_reg_d   = wr_mask ? mask_wr_data : mask_reg_q;

    // Upper config bits move only while disabled, so timing and rate
    // cannot shift under a running wake-up filter
    assign cfg_wr_data = keep_writable(req_in.data, CFG_REG_WRITABLE);
    assign cfg_upper_d = (wr_cfg && !locked) ? cfg_wr_data
                                             : cfg_reg_q;

    // Enable bit is written on every config write; a host can always
    // switch the filter off, even while the upper bits are locked
    assign enable_d  = wr_cfg ? req_in.data[SELECTIVE_WAKE_ENABLE_BIT]
                              : cfg_reg_q[SELECTIVE_WAKE_ENABLE_BIT];
    assign cfg_reg_d = {cfg_upper_d[15:1], enable_d};

    // Read mux; unmapped addresses read zero. The value is taken before
    // any write in the same cycle lands.
    assign rd_data_d  = sel_mask ? mask_reg_q
                      : sel_cfg  ? cfg_reg_q
                      : 16'h0000;
    assign rd_valid_d = req_in.valid && !req_in.write;

    // Standard identifier: a mask bit of 1 drops that bit from the compare
    ident_compare #(
        .WIDTH(11)
    ) u_std_cmp (
        .rx_ident_in  (rx_std_ident_in),
        .ref_ident_in (ref_std_ident_in),
        .mask_in      (mask_reg_q[STD_MASK_MSB:STD_MASK_LSB]),
        .match_out    (std_hit)
    );

    // Extended identifier bits 17:16 use the same masked compare
    ident_compare #(
        .WIDTH(2)
    ) u_ext_cmp (
        .rx_ident_in  (rx_ext_ident_top_in),
        .ref_ident_in (ref_ext_ident_top_in),
        .mask_in      (mask_reg_q[EXT_MASK_MSB:EXT_MASK_LSB]),
        .match_out    (ext_hit)
    );

    // Extended part only counts when the extension select is set; a
    // standard frame never fails on bits it does not carry
    assign ext_needed = ident_extension_select_in;
    assign match_d    = std_hit && (!ext_needed || ext_hit);

    // Settings view for the matcher and bit timing
    always_comb
    begin
        cfg_d.std_ident_mask        = mask_reg_d[STD_MASK_MSB:STD_MASK_LSB];
        cfg_d.ext_ident_mask        = mask_reg_d[EXT_MASK_MSB:EXT_MASK_LSB];
        cfg_d.sample_sel            = cfg_reg_d[SAMPLE_MSB:SAMPLE_LSB];
        cfg_d.bitrate_select        = cfg_reg_d[BITRATE_MSB:BITRATE_LSB];
        cfg_d.selective_wake_enable = cfg_reg_d[SELECTIVE_WAKE_ENABLE_BIT];
    end

    // Identifier mask register
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            mask_reg_q <= RST_WAKE_ID_MASK_HIGH;
        end
        else
        begin
            mask_reg_q <= mask_reg_d;
        end
    end

    // Filter configuration register
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            cfg_reg_q <= RST_WAKE_FILTER_CONFIG;
        end
        else
        begin
            cfg_reg_q <= cfg_reg_d;
        end
    end

    // Settings view, updated on the same edge as the registers
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            cfg_q <= '0;
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    // Read data, refreshed every cycle
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rd_data_q <= 16'h0000;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    // Read strobe, one cycle after each read request
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_valid_d;
        end
    end

    // Identifier match, one cycle after its inputs
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= match_d;
        end
    end

    // Outputs straight from flops
    assign cfg_out         = cfg_q;
    assign rd_data_out     = rd_data_q;
    assign rd_valid_out    = rd_valid_q;
    assign ident_match_out = match_q;
endmodule

// *** verif/wake_filter_cfg_asserts.sv ***
// Checker for the wake filter configuration block
`timescale 1ns/100ps
module wake_filter_cfg_asserts
    import wake_cfg_pkg::*;
(
    input wire logic                      clock_in,
    input wire logic                      rst_in,
    input wire wake_cfg_pkg::reg_req_s    req_in,
    input wire wake_cfg_pkg::filter_cfg_s cfg_out,
    input wire logic [15:0]               rd_data_out,
    input wire logic                      rd_valid_out,
    input wire logic                      ident_extension_select_in,
    input wire logic [10:0]               rx_std_ident_in,
    input wire logic [10:0]               ref_std_ident_in,
    input wire logic                      ident_match_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Decoded accesses: v any request, w a write
    wire logic        v = req_in.valid;
    wire logic        w = v & req_in.write;
    wire logic        c = req_in.addr == ADDR_WAKE_FILTER_CONFIG;
    wire logic        m = req_in.addr == ADDR_WAKE_ID_MASK_HIGH;
    wire logic        e = cfg_out.selective_wake_enable;
    wire logic [15:0] d = req_in.data;
    lock_hold_a: assert property (w & c & e |=>
        $stable(cfg_out[5:1])) else $error("locked field moved");
    sample_wr_a: assert property (w & c & !e |=>
        cfg_out.sample_sel == $past(d[6:4])) else $error("sample lost");
    rate_wr_a: assert property (w & c & !e |=>
        cfg_out.bitrate_select == $past(d[2:1])) else $error("rate lost");
    en_clear_a: assert property (w & c & !d[0] |=> !e)
        else $error("enable kept");
    std_wr_a: assert property (w & m |=>
        cfg_out.std_ident_mask == $past(d[12:2])) else $error("std lost");
    ext_wr_a: assert property (w & m |=>
        cfg_out.ext_ident_mask == $past(d[1:0])) else $error("ext lost");
    rd_mask_a: assert property (v & !w & m |=> rd_valid_out &&
        rd_data_out == {3'h0, $past(cfg_out[18:6])}) else $error("bad read");
    rd_cfg_a: assert property (v & !w & c |=> rd_valid_out &&
        rd_data_out[6:0] == {$past(cfg_out[5:3]), 1'h0, $past(cfg_out[2:0])})
        else $error("bad read");
    // Differing identifier bits that no mask bit covers
    wire logic [10:0] miss = (rx_std_ident_in ^ ref_std_ident_in)
                           & ~cfg_out.std_ident_mask;
    std_match_a: assert property (!ident_extension_select_in
        && miss == 11'h000 |=> ident_match_out) else $error("no match");
    std_miss_a: assert property (miss != 11'h000 |=>
        !ident_match_out) else $error("false match");
endmodule
bind wake_filter_cfg wake_filter_cfg_asserts u_wake_filter_cfg_asserts (.*);

// *** verif/wake_node_model.sv ***
// Bus node model presenting received wake frame identifiers
`timescale 1ns/100ps
module wake_node_model (
    input  wire logic        clock_in,
    output logic      [12:0] ident_out
);
    initial ident_out = 13'h0;
    // Frame launched after an edge; match is settled on return
    task automatic send(logic [12:0] i);
        @(posedge clock_in);
        ident_out <= i;
        @(posedge clock_in);
        #1;
    endtask
endmodule

// *** verif/wake_filter_cfg_tb.sv ***
// Self-checking bench for the wake filter configuration block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module wake_filter_cfg_tb;
    import wake_cfg_pkg::*;
    localparam logic [4:0] CA = ADDR_WAKE_FILTER_CONFIG;
    logic        clock_in, rst_in, ext_sel, rd_valid, match;
    reg_req_s    req;
    logic [12:0] rx, ref_id;
    filter_cfg_s cfg;
    logic [15:0] rd_data;
    int          n_fail = 0;
    int          tests_run = 0;
    wake_node_model u_wake_node_model (.clock_in(clock_in), .ident_out(rx));
    wake_filter_cfg u_wake_filter_cfg (.clock_in(clock_in), .rst_in(rst_in),
        .req_in(req), .ident_extension_select_in(ext_sel),
        .rx_std_ident_in(rx[12:2]), .rx_ext_ident_top_in(rx[1:0]),
        .ref_std_ident_in(ref_id[12:2]), .ref_ext_ident_top_in(ref_id[1:0]),
        .cfg_out(cfg), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .ident_match_out(match));
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // One access; valid held for exactly the taking edge
    task automatic acc(logic w, logic [4:0] a, logic [15:0] d);
        @(posedge clock_in);
        req <= '{1'b1, w, a, d};
        @(posedge clock_in);
        req.valid <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [4:0] a, logic [15:0] e);
        acc(1'b0, a, 16'h0);
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic t_regs;
        rd(5'h05, 16'h0);
        rd(CA, RST_WAKE_FILTER_CONFIG);
        acc(1'b1, ADDR_WAKE_ID_MASK_HIGH, 16'hffff);
        rd(ADDR_WAKE_ID_MASK_HIGH, 16'h1fff);
        acc(1'b1, ADDR_WAKE_ID_MASK_HIGH, 16'h0006);
        `CHK("ext_mask", 2'h2, cfg.ext_ident_mask)
        `CHK("std_mask", 11'h001, cfg.std_ident_mask)
        $display("t_regs done");
    endtask
    // Ident bit 0 and ext bit 17 are masked from here on
    task automatic t_match;
        u_wake_node_model.send(13'h0a92);
        `CHK("match", 1'b1, match)
        u_wake_node_model.send(13'h0a9d);
        `CHK("match", 1'b0, match)
        @(posedge clock_in);
        ext_sel <= 1'b1;
        u_wake_node_model.send(13'h0a94);
        `CHK("match", 1'b0, match)
        u_wake_node_model.send(13'h0a97);
        `CHK("match", 1'b1, match)
        $display("t_match done");
    endtask
    task automatic t_lock;
        acc(1'b1, CA, 16'h0050);
        `CHK("sample", SAMPLE_OPTIMUM, cfg.sample_sel)
        acc(1'b1, CA, 16'h0051);
        acc(1'b1, CA, 16'h0007);
        rd(CA, 16'h0051);
        acc(1'b1, CA, 16'h0000);
        rd(CA, 16'h0050);
        acc(1'b1, CA, 16'h0076);
        `CHK("rate", BITRATE_125K, cfg.bitrate_select)
        rd(CA, 16'h0076);
        $display("t_lock done");
    endtask
    // Mid-run reset returns every field to its zero default
    task automatic t_reset;
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        `CHK("rate", BITRATE_500K, cfg.bitrate_select)
        rd(CA, RST_WAKE_FILTER_CONFIG);
        rd(ADDR_WAKE_ID_MASK_HIGH, RST_WAKE_ID_MASK_HIGH);
        $display("t_reset done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        rst_in = 1'b1;
        req = '0;
        ext_sel = 1'b0;
        ref_id = 13'h0a95;
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        t_regs;
        t_match;
        t_lock;
        t_reset;
        report_and_stop;
    end
    // Watchdog; the run needs well under 200 cycles
    initial
    begin
        #5000;
        n_fail++;
        report_and_stop;
    end
endmodule
